// >>> verilog/dpram_pkg.sv
// Contract
// RQ1: address strobe drives only the valid flag
// RQ2: ready flag follows the port enable
// RQ3: valid flag is strobe delayed by latency
// RQ4: user strobes only while ready is high
// RQ5: port A width from 1 to 256
// RQ6: port A depth 2 to 1M, 256K small
// RQ7: port B width is A times power-of-two
// RQ8: B depth keeps total size, at least 2
// RQ9: ports read/write, write-only or read-only
// RQ10: write-first default, read-first, no-change modes
// RQ11: write-first shows written data after latency
// RQ12: read-first shows old data after latency
// RQ13: no-change write keeps last read data
// RQ14: optional input stage adds one cycle
// RQ15: optional extra output stage per port
// RQ16: enable, preset and handshake pins optional
// RQ17: selectable clock edge and control polarities
// RQ18: disabled port holds output, no write
// RQ19: preset loads output register, gated by enable
// RQ20: collisions store written data, reads may fail
// RQ21: valid line on port edge, cleared at reset
package dpram_pkg;

    localparam int unsigned DPRAM_APB_AW       = 8;
    localparam logic [7:0]  DPRAM_CTRL_OFS     = 8'h00;
    localparam logic [7:0]  DPRAM_STATUS_OFS   = 8'h04;
    localparam logic [7:0]  DPRAM_LATENCY_OFS  = 8'h08;
    localparam int unsigned DPRAM_CTRL_GATE_A  = 0;
    localparam int unsigned DPRAM_CTRL_GATE_B  = 1;
    localparam logic [1:0]  DPRAM_CTRL_RESET   = 2'h3;
    localparam int unsigned DPRAM_LAT_A_LSB    = 0;
    localparam int unsigned DPRAM_LAT_B_LSB    = 4;
    localparam int unsigned DPRAM_LAT_FIELD_W  = 4;

    localparam int unsigned DPRAM_WIDTH_MIN    = 1;
    localparam int unsigned DPRAM_WIDTH_MAX    = 256;
    localparam int unsigned DPRAM_DEPTH_MIN    = 2;
    localparam int unsigned DPRAM_DEPTH_MAX    = 1048576;
    localparam int unsigned DPRAM_DEPTH_MAX_SM = 262144;
    localparam int unsigned DPRAM_RATIO_MAX    = 32;
    localparam int unsigned DPRAM_RATIO_MAX_SM = 16;
    localparam int unsigned DPRAM_DEPTH_B_MIN  = 2;
    localparam int unsigned DPRAM_BASE_LAT     = 1;

    typedef enum logic [1:0] {
        DPRAM_WRITE_FIRST,
        DPRAM_READ_FIRST,
        DPRAM_NO_CHANGE
    } dpram_wmode_t;

    typedef enum logic [1:0] {
        DPRAM_READ_WRITE,
        DPRAM_WRITE_ONLY,
        DPRAM_READ_ONLY
    } dpram_pcfg_t;

    typedef struct packed {
        logic gate_b;
        logic gate_a;
    } dpram_ctrl_t;

    typedef struct packed {
        logic valid_b;
        logic valid_a;
        logic ready_b;
        logic ready_a;
    } dpram_status_t;

endpackage

// >>> verilog/dpram_handshake.sv
`timescale 1ns/10ps
module dpram_handshake
    import dpram_pkg::*;
#(
    parameter int unsigned LAT     = 1,
    parameter bit          PRESENT = 1'b1
) (
    input  logic clk,
    input  logic rst_n,
    input  logic ce,
    input  logic gate_active,
    input  logic new_address_strobe,
    output logic accept_ready_flag,
    output logic output_valid
);
    logic [LAT-1:0] line_q;

    // the line shifts regardless of the gate so the lag stays exact
    generate
        if (LAT == 1) begin : g_one
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    line_q <= '0; // RQ21
                end else if (ce) begin
                    line_q <= new_address_strobe; // RQ1
                end
            end
        end else begin : g_many
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    line_q <= '0; // RQ21
                end else if (ce) begin
                    line_q <= {line_q[LAT-2:0], new_address_strobe}; // RQ1
                end
            end
        end
    endgenerate

    assign output_valid      = PRESENT & line_q[LAT-1]; // RQ3
    assign accept_ready_flag = PRESENT & gate_active; // RQ2
endmodule

// >>> verilog/dpram_top.sv
`timescale 1ns/10ps
module dpram_top
    import dpram_pkg::*;
#(
    parameter bit           SMALL_PRIM    = 1'b0,
    parameter int unsigned  WIDTH_A       = 8,
    parameter int unsigned  DEPTH_A       = 256,
    parameter int unsigned  RATIO         = 1,
    parameter dpram_pcfg_t  CFG_A         = DPRAM_READ_WRITE,
    parameter dpram_pcfg_t  CFG_B         = DPRAM_READ_WRITE,
    parameter dpram_wmode_t MODE_A        = DPRAM_WRITE_FIRST,
    parameter dpram_wmode_t MODE_B        = DPRAM_WRITE_FIRST,
    parameter bit           IN_REG_A      = 1'b0,
    parameter bit           IN_REG_B      = 1'b0,
    parameter bit           OUT_REG_A     = 1'b0,
    parameter bit           OUT_REG_B     = 1'b0,
    parameter bit           HAS_GATE_A    = 1'b1,
    parameter bit           HAS_GATE_B    = 1'b1,
    parameter bit           HAS_PRESET_A  = 1'b1,
    parameter bit           HAS_PRESET_B  = 1'b1,
    parameter bit           HAS_HS_A      = 1'b1,
    parameter bit           HAS_HS_B      = 1'b1,
    parameter bit           NEG_EDGE      = 1'b0,
    parameter bit           GATE_LOW_A    = 1'b0,
    parameter bit           GATE_LOW_B    = 1'b0,
    parameter bit           STORE_LOW_A   = 1'b0,
    parameter bit           STORE_LOW_B   = 1'b0,
    parameter bit           PRESET_LOW_A  = 1'b0,
    parameter bit           PRESET_LOW_B  = 1'b0,
    parameter logic [WIDTH_A-1:0]       PRESET_VAL_A = '0,
    parameter logic [WIDTH_A*RATIO-1:0] PRESET_VAL_B = '0,
    localparam int unsigned WIDTH_B  = WIDTH_A * RATIO,
    localparam int unsigned DEPTH_B  = DEPTH_A / RATIO,
    localparam int unsigned AW_A     = (DEPTH_A > 1) ? $clog2(DEPTH_A) : 1,
    localparam int unsigned AW_B     = (DEPTH_B > 1) ? $clog2(DEPTH_B) : 1
) (
    input  logic                    pclk,
    input  logic                    presetn,
    input  logic                    ce,

    input  logic                    psel,
    input  logic                    penable,
    input  logic                    pwrite,
    input  logic [DPRAM_APB_AW-1:0] paddr,
    input  logic [31:0]             pwdata,
    input  logic [3:0]              pstrb,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,

    input  logic                    port_a_gate,
    input  logic                    port_a_store_strobe,
    input  logic                    port_a_output_preset,
    input  logic [AW_A-1:0]         port_a_addr,
    input  logic [WIDTH_A-1:0]      port_a_write_bus,
    output logic [WIDTH_A-1:0]      port_a_read_bus,
    input  logic                    port_a_new_address_strobe,
    output logic                    port_a_accept_ready_flag,
    output logic                    port_a_output_valid,

    input  logic                    port_b_gate,
    input  logic                    port_b_store_strobe,
    input  logic                    port_b_output_preset,
    input  logic [AW_B-1:0]         port_b_addr,
    input  logic [WIDTH_B-1:0]      port_b_write_bus,
    output logic [WIDTH_B-1:0]      port_b_read_bus,
    input  logic                    port_b_new_address_strobe,
    output logic                    port_b_accept_ready_flag,
    output logic                    port_b_output_valid
);
    localparam int unsigned LAT_A = DPRAM_BASE_LAT + IN_REG_A + OUT_REG_A;
    localparam int unsigned LAT_B = DPRAM_BASE_LAT + IN_REG_B + OUT_REG_B;
    localparam int unsigned DMAX  = SMALL_PRIM ? DPRAM_DEPTH_MAX_SM : DPRAM_DEPTH_MAX;
    localparam int unsigned RMAX  = SMALL_PRIM ? DPRAM_RATIO_MAX_SM : DPRAM_RATIO_MAX;

    // elaboration checks on the build options
    generate
        if (WIDTH_A < DPRAM_WIDTH_MIN || WIDTH_A > DPRAM_WIDTH_MAX) begin : g_bad_w
            $error("port A width out of range"); // RQ5
        end
        if (DEPTH_A < DPRAM_DEPTH_MIN || DEPTH_A > DMAX) begin : g_bad_d
            $error("port A depth out of range"); // RQ6
        end
        if (RATIO < 1 || RATIO > RMAX || (RATIO & (RATIO - 1)) != 0) begin : g_bad_r
            $error("width ratio must be a power of two within limit"); // RQ7
        end
        if (DEPTH_A % RATIO != 0 || DEPTH_B < DPRAM_DEPTH_B_MIN) begin : g_bad_db
            $error("port B depth invalid"); // RQ8
        end
        if (CFG_A == DPRAM_WRITE_ONLY && CFG_B == DPRAM_WRITE_ONLY) begin : g_bad_cfg
            $error("only one port may be write-only"); // RQ9
        end
        if (SMALL_PRIM && (MODE_A != DPRAM_WRITE_FIRST || MODE_B != DPRAM_WRITE_FIRST)) begin : g_bad_m
            $error("small primitive supports write-first only"); // RQ10
        end
        if (SMALL_PRIM && (PRESET_VAL_A != '0 || PRESET_VAL_B != '0)) begin : g_bad_p
            $error("small primitive preset value must be zero"); // RQ19
        end
    endgenerate

    // one clock for both ports; a falling-edge build inverts it
    logic mem_clk;
    assign mem_clk = NEG_EDGE ? ~pclk : pclk; // RQ17

    dpram_ctrl_t   ctrl_q;
    dpram_status_t status;
    logic [31:0]   prdata_q;

    // normalised controls
    logic gate_a;
    logic gate_b;
    logic store_a;
    logic store_b;
    logic preset_a;
    logic preset_b;

    assign gate_a   = (HAS_GATE_A ? (port_a_gate ^ GATE_LOW_A) : 1'b1) & ctrl_q.gate_a; // RQ16 RQ17
    assign gate_b   = (HAS_GATE_B ? (port_b_gate ^ GATE_LOW_B) : 1'b1) & ctrl_q.gate_b; // RQ16 RQ17
    assign store_a  = (port_a_store_strobe ^ STORE_LOW_A) & (CFG_A != DPRAM_READ_ONLY); // RQ9 RQ17
    assign store_b  = (port_b_store_strobe ^ STORE_LOW_B) & (CFG_B != DPRAM_READ_ONLY); // RQ9 RQ17
    assign preset_a = HAS_PRESET_A & (port_a_output_preset ^ PRESET_LOW_A); // RQ16 RQ17
    assign preset_b = HAS_PRESET_B & (port_b_output_preset ^ PRESET_LOW_B); // RQ16 RQ17

    // address, data and write strobe as seen by the array
    logic [AW_A-1:0]    m_addr_a;
    logic [AW_B-1:0]    m_addr_b;
    logic [WIDTH_A-1:0] m_din_a;
    logic [WIDTH_B-1:0] m_din_b;
    logic               m_we_a;
    logic               m_we_b;

    generate
        if (IN_REG_A) begin : g_in_a
            logic [AW_A-1:0]    addr_q;
            logic [WIDTH_A-1:0] din_q;
            logic               we_q;
            always_ff @(posedge mem_clk or negedge presetn) begin
                if (!presetn) begin
                    addr_q <= '0;
                    din_q  <= '0;
                    we_q   <= 1'b0;
                end else if (ce) begin
                    addr_q <= port_a_addr; // RQ14
                    din_q  <= port_a_write_bus; // RQ14
                    we_q   <= store_a; // RQ14
                end
            end
            assign m_addr_a = addr_q;
            assign m_din_a  = din_q;
            assign m_we_a   = we_q;
        end else begin : g_dir_a
            assign m_addr_a = port_a_addr;
            assign m_din_a  = port_a_write_bus;
            assign m_we_a   = store_a;
        end
        if (IN_REG_B) begin : g_in_b
            logic [AW_B-1:0]    addr_q;
            logic [WIDTH_B-1:0] din_q;
            logic               we_q;
            always_ff @(posedge mem_clk or negedge presetn) begin
                if (!presetn) begin
                    addr_q <= '0;
                    din_q  <= '0;
                    we_q   <= 1'b0;
                end else if (ce) begin
                    addr_q <= port_b_addr; // RQ14
                    din_q  <= port_b_write_bus; // RQ14
                    we_q   <= store_b; // RQ14
                end
            end
            assign m_addr_b = addr_q;
            assign m_din_b  = din_q;
            assign m_we_b   = we_q;
        end else begin : g_dir_b
            assign m_addr_b = port_b_addr;
            assign m_din_b  = port_b_write_bus;
            assign m_we_b   = store_b;
        end
    endgenerate

    // storage kept in port A words; a B word spans RATIO of them, lowest first
    logic [WIDTH_A-1:0] mem [DEPTH_A];
    logic [WIDTH_A-1:0] rd_a;
    logic [WIDTH_B-1:0] rd_b;

    function automatic int unsigned b_index(input logic [AW_B-1:0] addr, input int unsigned lane);
        b_index = int'(addr) * RATIO + lane;
    endfunction

    assign rd_a = (int'(m_addr_a) < DEPTH_A) ? mem[m_addr_a] : '0;

    generate
        for (genvar g = 0; g < RATIO; g++) begin : g_lane
            assign rd_b[g*WIDTH_A +: WIDTH_A] =
                (b_index(m_addr_b, g) < DEPTH_A) ? mem[AW_A'(b_index(m_addr_b, g))] : '0;
        end
    endgenerate

    // port B writes after port A so a same-word collision still stores one whole word
    always_ff @(posedge mem_clk) begin
        if (ce) begin
            if (gate_a && m_we_a && int'(m_addr_a) < DEPTH_A) begin
                mem[m_addr_a] <= m_din_a; // RQ18 RQ20
            end
            for (int i = 0; i < RATIO; i++) begin
                if (gate_b && m_we_b && b_index(m_addr_b, i) < DEPTH_A) begin
                    mem[AW_A'(b_index(m_addr_b, i))] <= m_din_b[i*WIDTH_A +: WIDTH_A]; // RQ18 RQ20
                end
            end
        end
    end

    // first output stage: the read latch of each port
    logic [WIDTH_A-1:0] lat_a_q;
    logic [WIDTH_B-1:0] lat_b_q;

    always_ff @(posedge mem_clk or negedge presetn) begin
        if (!presetn) begin
            lat_a_q <= '0;
        end else if (ce && gate_a) begin // RQ18
            if (preset_a) begin
                lat_a_q <= PRESET_VAL_A; // RQ19
            end else if (m_we_a) begin
                case (MODE_A)
                    DPRAM_WRITE_FIRST: lat_a_q <= m_din_a; // RQ11
                    DPRAM_READ_FIRST:  lat_a_q <= rd_a; // RQ12
                    DPRAM_NO_CHANGE:   lat_a_q <= lat_a_q; // RQ13
                    default:           lat_a_q <= m_din_a;
                endcase
            end else begin
                lat_a_q <= rd_a;
            end
        end
    end

    always_ff @(posedge mem_clk or negedge presetn) begin
        if (!presetn) begin
            lat_b_q <= '0;
        end else if (ce && gate_b) begin // RQ18
            if (preset_b) begin
                lat_b_q <= PRESET_VAL_B; // RQ19
            end else if (m_we_b) begin
                case (MODE_B)
                    DPRAM_WRITE_FIRST: lat_b_q <= m_din_b; // RQ11
                    DPRAM_READ_FIRST:  lat_b_q <= rd_b; // RQ12
                    DPRAM_NO_CHANGE:   lat_b_q <= lat_b_q; // RQ13
                    default:           lat_b_q <= m_din_b;
                endcase
            end else begin
                lat_b_q <= rd_b;
            end
        end
    end

    // optional extra output stage; preset reaches it too so the pin shows the value at once
    logic [WIDTH_A-1:0] out_a;
    logic [WIDTH_B-1:0] out_b;

    generate
        if (OUT_REG_A) begin : g_out_a
            logic [WIDTH_A-1:0] pipe_q;
            always_ff @(posedge mem_clk or negedge presetn) begin
                if (!presetn) begin
                    pipe_q <= '0;
                end else if (ce && gate_a) begin // RQ18
                    pipe_q <= preset_a ? PRESET_VAL_A : lat_a_q; // RQ15 RQ19
                end
            end
            assign out_a = pipe_q;
        end else begin : g_noout_a
            assign out_a = lat_a_q;
        end
        if (OUT_REG_B) begin : g_out_b
            logic [WIDTH_B-1:0] pipe_q;
            always_ff @(posedge mem_clk or negedge presetn) begin
                if (!presetn) begin
                    pipe_q <= '0;
                end else if (ce && gate_b) begin // RQ18
                    pipe_q <= preset_b ? PRESET_VAL_B : lat_b_q; // RQ15 RQ19
                end
            end
            assign out_b = pipe_q;
        end else begin : g_noout_b
            assign out_b = lat_b_q;
        end
    endgenerate

    // a write-only port has no read bus; it reads as zero
    assign port_a_read_bus = (CFG_A == DPRAM_WRITE_ONLY) ? '0 : out_a; // RQ9
    assign port_b_read_bus = (CFG_B == DPRAM_WRITE_ONLY) ? '0 : out_b; // RQ9

    // handshake; strobes outside the ready window are the user's fault and are not filtered
    dpram_handshake #(
        .LAT     (LAT_A),
        .PRESENT (HAS_HS_A)
    ) u_hs_a (
        .clk                (mem_clk),
        .rst_n              (presetn),
        .ce                 (ce),
        .gate_active        (gate_a),
        .new_address_strobe (port_a_new_address_strobe), // RQ4
        .accept_ready_flag  (port_a_accept_ready_flag),
        .output_valid       (port_a_output_valid)
    );

    dpram_handshake #(
        .LAT     (LAT_B),
        .PRESENT (HAS_HS_B)
    ) u_hs_b (
        .clk                (mem_clk),
        .rst_n              (presetn),
        .ce                 (ce),
        .gate_active        (gate_b),
        .new_address_strobe (port_b_new_address_strobe), // RQ4
        .accept_ready_flag  (port_b_accept_ready_flag),
        .output_valid       (port_b_output_valid)
    );

    // apb slave; ce low stalls the bus instead of dropping writes
    logic access;
    logic mapped;

    assign access = psel & penable;
    assign mapped = (paddr == DPRAM_CTRL_OFS) || (paddr == DPRAM_STATUS_OFS)
                 || (paddr == DPRAM_LATENCY_OFS);
    assign pready  = ce;
    assign pslverr = access & ~mapped;
    assign prdata  = prdata_q;

    assign status.valid_b = port_b_output_valid;
    assign status.valid_a = port_a_output_valid;
    assign status.ready_b = port_b_accept_ready_flag;
    assign status.ready_a = port_a_accept_ready_flag;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= DPRAM_CTRL_RESET;
        end else if (ce && access && pwrite && pstrb[0] && paddr == DPRAM_CTRL_OFS) begin
            ctrl_q.gate_a <= pwdata[DPRAM_CTRL_GATE_A];
            ctrl_q.gate_b <= pwdata[DPRAM_CTRL_GATE_B];
        end
    end

    // read data is captured in the setup cycle, one cycle before it is taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (ce && psel && !penable && !pwrite) begin
            prdata_q <= '0;
            case (paddr)
                DPRAM_CTRL_OFS: begin
                    prdata_q[DPRAM_CTRL_GATE_A] <= ctrl_q.gate_a;
                    prdata_q[DPRAM_CTRL_GATE_B] <= ctrl_q.gate_b;
                end
                DPRAM_STATUS_OFS: begin
                    prdata_q[$bits(dpram_status_t)-1:0] <= status;
                end
                DPRAM_LATENCY_OFS: begin
                    prdata_q[DPRAM_LAT_A_LSB +: DPRAM_LAT_FIELD_W] <= DPRAM_LAT_FIELD_W'(LAT_A);
                    prdata_q[DPRAM_LAT_B_LSB +: DPRAM_LAT_FIELD_W] <= DPRAM_LAT_FIELD_W'(LAT_B);
                end
                default: begin
                    prdata_q <= '0;
                end
            endcase
        end
    end
endmodule

// >>> dv/dpram_checker.sv
`timescale 1ns/10ps
module dpram_checker
    import dpram_pkg::*;
#(
    parameter int unsigned        WIDTH_A      = 8,
    parameter int unsigned        RATIO        = 1,
    parameter logic [WIDTH_A-1:0] PRESET_VAL_A = '0
) (
    input logic                     pclk,
    input logic                     presetn,
    input logic                     ce,
    input logic                     port_a_gate,
    input logic                     port_a_store_strobe,
    input logic                     port_a_output_preset,
    input logic [WIDTH_A-1:0]       port_a_write_bus,
    input logic [WIDTH_A-1:0]       port_a_read_bus,
    input logic                     port_a_new_address_strobe,
    input logic                     port_a_accept_ready_flag,
    input logic                     port_a_output_valid,
    input logic                     port_b_gate,
    input logic [WIDTH_A*RATIO-1:0] port_b_read_bus,
    input logic                     port_b_new_address_strobe,
    input logic                     port_b_accept_ready_flag,
    input logic                     port_b_output_valid
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy_a; port_a_accept_ready_flag |-> port_a_gate; endproperty
    a_rdy_a: assert property (p_rdy_a) else $error("ready a without gate");
    property p_rdy_b; port_b_accept_ready_flag |-> port_b_gate; endproperty
    a_rdy_b: assert property (p_rdy_b) else $error("ready b without gate");
    property p_vld_a; ce |=> port_a_output_valid == $past(port_a_new_address_strobe); endproperty
    a_vld_a: assert property (p_vld_a) else $error("valid a not strobe delayed");
    property p_vld_b; ce |=> port_b_output_valid == $past(port_b_new_address_strobe); endproperty
    a_vld_b: assert property (p_vld_b) else $error("valid b not strobe delayed");
    property p_hold_a; !port_a_gate |=> $stable(port_a_read_bus); endproperty
    a_hold_a: assert property (p_hold_a) else $error("read a moved while gated");
    property p_hold_b; !port_b_gate |=> $stable(port_b_read_bus); endproperty
    a_hold_b: assert property (p_hold_b) else $error("read b moved while gated");
    property p_wf_a;
        ce && port_a_gate && port_a_store_strobe && !port_a_output_preset
            |=> port_a_read_bus == $past(port_a_write_bus);
    endproperty
    a_wf_a: assert property (p_wf_a) else $error("write data not mirrored on a");
    property p_pre_a; ce && port_a_gate && port_a_output_preset |=> port_a_read_bus == PRESET_VAL_A; endproperty
    a_pre_a: assert property (p_pre_a) else $error("preset value not loaded on a");
endmodule

// >>> dv/dpram_user_model.sv
`timescale 1ns/10ps
module dpram_user_model (
    input  logic        clk,
    input  logic        a_rdy,
    input  logic        b_rdy,
    output logic [3:0]  a_ctl,
    output logic [7:0]  a_ad,
    output logic [7:0]  a_di,
    output logic [3:0]  b_ctl,
    output logic [6:0]  b_ad,
    output logic [15:0] b_di
);
    // ctl is {gate, store, preset, strobe}; idle keeps the gate on
    initial begin
        a_ctl = 4'h8;
        a_ad = 8'h00;
        a_di = 8'h00;
        b_ctl = 4'h8;
        b_ad = 7'h00;
        b_di = 16'h0000;
    end
    task automatic pa(input logic [3:0] c, input logic [7:0] ad, input logic [7:0] di);
        @(posedge clk);
        a_ctl <= {c[3:1], c[0] & c[3] & a_rdy};
        a_ad <= ad;
        a_di <= di;
        @(posedge clk);
        a_ctl <= 4'h8;
        a_di <= ~di;
        #1;
    endtask
    task automatic pb(input logic [3:0] c, input logic [6:0] ad, input logic [15:0] di);
        @(posedge clk);
        b_ctl <= {c[3:1], c[0] & c[3] & b_rdy};
        b_ad <= ad;
        b_di <= di;
        @(posedge clk);
        b_ctl <= 4'h8;
        b_di <= ~di;
        #1;
    endtask
endmodule

// >>> dv/tb.sv
`timescale 1ns/10ps
module tb;
    import dpram_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pslverr, pready, serr, ce;
    logic [7:0]  paddr, a_ad, a_di, a_do;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  a_ctl, b_ctl;
    logic [6:0]  b_ad;
    logic [15:0] b_di, b_do;
    logic        a_rdy, a_vld, b_rdy, b_vld;
    int          n_errors = 0;
    int          n_compared = 0;

    dpram_top #(.RATIO(2), .MODE_B(DPRAM_READ_FIRST), .PRESET_VAL_A(8'h5a)) dpram_top_i (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_a_gate(a_ctl[3]), .port_a_store_strobe(a_ctl[2]),
        .port_a_output_preset(a_ctl[1]), .port_a_addr(a_ad), .port_a_write_bus(a_di),
        .port_a_read_bus(a_do), .port_a_new_address_strobe(a_ctl[0]), .port_a_accept_ready_flag(a_rdy),
        .port_a_output_valid(a_vld), .port_b_gate(b_ctl[3]), .port_b_store_strobe(b_ctl[2]),
        .port_b_output_preset(b_ctl[1]), .port_b_addr(b_ad), .port_b_write_bus(b_di),
        .port_b_read_bus(b_do), .port_b_new_address_strobe(b_ctl[0]), .port_b_accept_ready_flag(b_rdy),
        .port_b_output_valid(b_vld));
    dpram_user_model dpram_user_model_i (.clk(pclk), .a_rdy(a_rdy), .b_rdy(b_rdy), .a_ctl(a_ctl),
        .a_ad(a_ad), .a_di(a_di), .b_ctl(b_ctl), .b_ad(b_ad), .b_di(b_di));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        #100us;
        n_errors++;
        $display("watchdog expired");
        stop_test;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ce = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, DPRAM_CTRL_OFS, 32'h0);
        chk("ctrl", rd, 32'h3);
        apb(1'b0, DPRAM_STATUS_OFS, 32'h0);
        chk("status", rd, 32'h3);
        apb(1'b0, DPRAM_LATENCY_OFS, 32'h0);
        chk("latency", rd, 32'h11);
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("slverr", serr, 32'h1);
        apb(1'b1, DPRAM_CTRL_OFS, 32'h2);
        #1 chk("ready_a", a_rdy, 32'h0);
        apb(1'b1, DPRAM_CTRL_OFS, 32'h3);
        $display("test registers done");
        // both a words of b word 2 are written through the narrow port
        dpram_user_model_i.pa(4'hd, 8'h04, 8'h34);
        chk("wfirst_a", a_do, 32'h34);
        chk("valid_a", a_vld, 32'h1);
        dpram_user_model_i.pa(4'hc, 8'h05, 8'h12);
        chk("wfirst_a", a_do, 32'h12);
        chk("valid_a", a_vld, 32'h0);
        dpram_user_model_i.pb(4'hc, 7'h02, 16'hbeef);
        chk("rfirst_b", b_do, 32'h1234);
        dpram_user_model_i.pa(4'h8, 8'h05, 8'h00);
        chk("lane1", a_do, 32'hbe);
        $display("test write modes done");
        dpram_user_model_i.pa(4'h5, 8'h04, 8'h77);
        chk("gated_hold", a_do, 32'hbe);
        chk("gated_valid", a_vld, 32'h0);
        dpram_user_model_i.pa(4'ha, 8'h04, 8'h00);
        chk("preset", a_do, 32'h5a);
        dpram_user_model_i.pa(4'h8, 8'h04, 8'h00);
        chk("lane0", a_do, 32'hef);
        // clock enable low: the write must not land and the bus stalls
        @(posedge pclk) ce <= 1'b0;
        dpram_user_model_i.pa(4'hc, 8'h04, 8'h99);
        chk("ce_hold", a_do, 32'hef);
        chk("ce_pready", pready, 32'h0);
        @(posedge pclk) ce <= 1'b1;
        dpram_user_model_i.pa(4'h8, 8'h04, 8'h00);
        chk("ce_no_write", a_do, 32'hef);
        // the array is not reset, so only words written earlier are read back
        dpram_user_model_i.pb(4'hd, 7'h02, 16'h5678);
        chk("rfirst_b_new", b_do, 32'hbeef);
        chk("valid_b", b_vld, 32'h1);
        dpram_user_model_i.pb(4'h8, 7'h02, 16'h0000);
        chk("read_b", b_do, 32'h5678);
        dpram_user_model_i.pb(4'h4, 7'h02, 16'h1111);
        chk("gated_b", b_do, 32'h5678);
        $display("test gate and preset done");
        stop_test;
    end
endmodule

bind dpram_top dpram_checker #(.WIDTH_A(WIDTH_A), .RATIO(RATIO), .PRESET_VAL_A(PRESET_VAL_A)) dpram_checker_i (
    .pclk, .presetn, .ce, .port_a_gate, .port_a_store_strobe, .port_a_output_preset, .port_a_write_bus,
    .port_a_read_bus, .port_a_new_address_strobe, .port_a_accept_ready_flag, .port_a_output_valid,
    .port_b_gate, .port_b_read_bus, .port_b_new_address_strobe, .port_b_accept_ready_flag,
    .port_b_output_valid);
